/* rtl/upc_pkg.sv */
// Shared constants and carriers for the controller-side register block.
// Assumes one 100 MHz clock and a synchronous active-low reset.
package upc_pkg;

	// ****************************************
	// Register indexes
	// ****************************************
	localparam logic [7:0] IDX_PACKET_FIFO_PORT = 8'h00;
	localparam logic [7:0] IDX_IRQ = 8'h01;
	localparam logic [7:0] IDX_WCL = 8'h02;
	localparam logic [7:0] IDX_WCH = 8'h03;
	localparam logic [7:0] IDX_TRIG = 8'h06;
	localparam logic [7:0] IDX_XACK = 8'h07;
	localparam logic [7:0] IDX_DIACK = 8'h0E;
	localparam logic [7:0] IDX_STATUS_THREE = 8'h0F;
	localparam logic [7:0] IDX_AUTO = 8'h17;
	localparam logic [7:0] IDX_APKT = 8'h18;
	localparam logic [7:0] IDX_DFCTL = 8'h1F;
	localparam logic [7:0] IDX_HCTL = 8'h20;
	localparam logic [7:0] IDX_SUB = 8'h22;
	localparam logic [7:0] IDX_DATA_FIFO_RESET = 8'h2B;
	localparam logic [7:0] IDX_SUBEN = 8'h2C;
	localparam logic [7:0] IDX_HIEN = 8'h2E;
	localparam logic [7:0] IDX_RSTEN = 8'h2F;
	localparam logic [7:0] IDX_XSTAT = 8'h30;
	localparam logic [7:0] IDX_BCL = 8'h34;
	localparam logic [7:0] IDX_CMD = 8'h37;
	localparam logic [7:0] IDX_LATCHED_STATUS_THREE = 8'h4B;
	localparam logic [7:0] IDX_MUX = 8'h5B;
	localparam logic [7:0] IDX_CFG = 8'h5C;
	localparam logic [7:0] IDX_TSTA = 8'h80;
	localparam logic [7:0] IDX_PLAY = 8'h90;
	localparam logic [7:0] IDX_PACK = 8'h97;

	// ****************************************
	// Bit positions
	// ****************************************
	localparam int B_PNE_EN = 7;
	localparam int B_TEND_EN = 6;
	localparam int B_SRI_EN = 5;
	localparam int B_DT_EN = 1;
	localparam int B_MUX = 1;
	localparam int B_LATCH_PIN_TWO = 3;
	localparam int B_REMAP = 0;
	localparam int B_PKTSEL = 2;
	localparam int B_CLEAR_BUSY = 4;
	localparam int B_HOST_IRQ_EN = 7;
	localparam int B_ABSENT_SLAVE_EN = 2;
	localparam int B_RSTIEN = 1;
	localparam int B_DIR = 5;
	localparam int B_DEVRST = 3;
	localparam int B_FULL = 1;
	localparam int B_AUTO = 2;
	localparam int B_APKT = 7;
	localparam int B_DIRO = 1;
	localparam int B_DATA_FIFO_RESET = 3;
	localparam int B_SUBCODE_IRQ_EN = 4;
	localparam int B_PLAYBACK_IRQ_EN = 6;

	// ****************************************
	// Commands, sizes, reset values
	// ****************************************
	localparam logic [7:0] CMD_PACKET = 8'h00A0;
	localparam logic [7:0] CMD_DEVRST = 8'h0008;
	localparam logic [7:0] CMD_DIAG = 8'h0090;
	localparam logic [7:0] EMPTY_READ = 8'h00FF;
	localparam logic [3:0] THRESH_RST = 4'hC;
	localparam logic [5:0] DF_BYTES = 6'h20;
	localparam int PKT_DEPTH = 16;
	localparam int PKT_BYTES = 12;

	// Host-side events, all on the chip clock
	typedef struct packed {
		logic wr_stb;
		logic [7:0] wr_data;
		logic word_rd;
		logic cmd_valid;
		logic [7:0] cmd_code;
		logic selected;
		logic soft_reset;
		logic absent_slave;
		logic out_done;
		logic drq;
	} host_evt_t;

	// Decoder, playback and reset events, all on the chip clock
	typedef struct packed {
		logic host_reset;
		logic fw_reset;
		logic dec_reset;
		logic sector_ready;
		logic [6:0] target_evt;
		logic play_done;
		logic [2:0] subcode;
	} sys_evt_t;

endpackage : upc_pkg

/* rtl/pin_sync.sv */
// Two-flop synchroniser for a bundle of pin inputs.
// Assumes each bit is an independent level; no bus coherence.
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;
	logic [WIDTH-1:0] nxt_meta;
	logic [WIDTH-1:0] nxt_sync;

	always_comb begin
		nxt_meta = pin_in;
		nxt_sync = meta_ff;
	end

	// Pins idle high, so reset to ones
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			meta_ff <= '1;
			sync_ff <= '1;
		end else begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
		end
	end

	assign sync_out = sync_ff;
endmodule : pin_sync

/* rtl/byte_fifo.sv */
// Synchronous FIFO with valid/ready on both sides and a flush.
// Assumes DEPTH is a power of two; read data is shown ahead.
`timescale 1ns/1ps
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH):0] count
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wp_ff, rp_ff, nxt_wp, nxt_rp;
	logic [AW:0] cnt_ff, nxt_cnt;
	logic push, pop;

	always_comb begin
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		nxt_wp = push ? wp_ff + 1'b1 : wp_ff;
		nxt_rp = pop ? rp_ff + 1'b1 : rp_ff;
		nxt_cnt = cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		if (flush) begin
			nxt_wp = '0;
			nxt_rp = '0;
			nxt_cnt = '0;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			wp_ff <= '0;
			rp_ff <= '0;
			cnt_ff <= '0;
		end else begin
			wp_ff <= nxt_wp;
			rp_ff <= nxt_rp;
			cnt_ff <= nxt_cnt;
		end
	end

	always_ff @(posedge clock) begin
		if (push) begin
			mem[wp_ff] <= in_data;
		end
	end

	assign in_ready = (cnt_ff != DEPTH[AW:0]) && !flush;
	assign out_valid = (cnt_ff != '0);
	assign out_data = mem[rp_ff];
	assign count = cnt_ff;
endmodule : byte_fifo

/* rtl/upc_index_irq.sv */
// Controller-side indexed register access, packet FIFO and event flags.
// Assumes host-protocol and decoder logic deliver one-cycle event pulses
// on the same clock; controller bus pins arrive asynchronously.
`timescale 1ns/1ps
module upc_index_irq import upc_pkg::*; #(
	parameter int PKT_FIFO_DEPTH = PKT_DEPTH
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic cs_b,
	input wire logic rd_b,
	input wire logic wr_b,
	input wire logic reg_select_pin,
	input wire logic latch_pin_one,
	input wire logic latch_pin_two,
	input wire logic [7:0] ud_in,
	output logic [7:0] ud_out,
	output logic ud_oe,
	output logic ctrl_irq_pin_oe,
	input wire host_evt_t host_evt,
	output logic host_wr_ready,
	input wire sys_evt_t sys_evt
);
	// ****************************************
	// Pin synchronisation and strobe edges
	// ****************************************
	logic [13:0] pins_s;
	logic [13:0] pins_p_ff, nxt_pins_p;
	logic s_cs_b, s_rd_b, s_wr_b, s_rs, s_latch_pin_one, s_latch_pin_two;
	logic [7:0] s_ud;
	logic p_rd_b, p_wr_b, p_latch_pin_one, p_latch_pin_two;

	pin_sync #(.WIDTH(14)) u_sync (
		.clock(clock),
		.rst_b(rst_b),
		.pin_in({cs_b, rd_b, wr_b, reg_select_pin, latch_pin_one,
			latch_pin_two, ud_in}),
		.sync_out(pins_s)
	);

	assign {s_cs_b, s_rd_b, s_wr_b, s_rs, s_latch_pin_one, s_latch_pin_two, s_ud} = pins_s;
	assign p_rd_b = pins_p_ff[12];
	assign p_wr_b = pins_p_ff[11];
	assign p_latch_pin_one = pins_p_ff[9];
	assign p_latch_pin_two = pins_p_ff[8];

	// ****************************************
	// State declarations
	// ****************************************
	logic [7:0] index_ff, nxt_index;
	logic [7:0] ud_out_ff, nxt_ud_out;
	logic ud_oe_ff, nxt_ud_oe, irq_ff, nxt_irq, hwr_rdy_ff, nxt_hwr_rdy;
	logic [7:0] irq_enable_ctrl_ff, nxt_irq_enable_ctrl, mux_ff, nxt_mux, cfg_ff, nxt_cfg;
	logic [7:0] hctl_ff, nxt_hctl, hien_ff, nxt_hien, rsten_ff, nxt_rsten;
	logic [7:0] bcl_ff, nxt_bcl, play_ff, nxt_play, cmd_ff, nxt_cmd;
	logic apkt_ff, nxt_apkt, diro_ff, nxt_diro, data_fifo_reset_ff, nxt_data_fifo_reset;
	logic subcode_irq_en_ff, nxt_subcode_irq_en;
	logic [11:0] wc_ff, nxt_wc;
	logic [3:0] thr_ff, nxt_thr;
	logic [5:0] dfc_ff, nxt_dfc;
	logic [2:0] subc_ff, nxt_subc, subp_ff, nxt_subp;
	logic pne_ff, tend_ff, full_ff, dir_ff, sri_ff, hci_ff, devrst_ff;
	logic busy_ff, api_ff, sci_ff, dineed_ff, xgot_ff, drqp_ff;
	logic nxt_pne, nxt_tend, nxt_full, nxt_dir, nxt_sri, nxt_hci, nxt_devrst;
	logic nxt_busy, nxt_api, nxt_sci, nxt_dineed, nxt_xgot, nxt_drqp;
	logic push_ff, nxt_push;

	// ****************************************
	// Access decode
	// ****************************************
	logic mux_mode, rd_go, wr_go, idx_acc, reg_rd, reg_wr, ale_fall;
	logic [7:0] rd_val;
	logic pkt_pop, pkt_push, pkt_in_rdy, pkt_valid;
	logic [7:0] pkt_data;
	logic [$clog2(PKT_FIFO_DEPTH):0] pkt_cnt;

	function automatic logic wr_to(input logic [7:0] idx);
		wr_to = reg_wr && (index_ff == idx);
	endfunction : wr_to

	function automatic logic rd_of(input logic [7:0] idx);
		rd_of = reg_rd && (index_ff == idx);
	endfunction : rd_of

	always_comb begin
		mux_mode = mux_ff[B_MUX];
		rd_go = !s_cs_b && p_rd_b && !s_rd_b;
		// Writes commit on the trailing edge, when the data is settled
		wr_go = !s_cs_b && !p_wr_b && s_wr_b;
		idx_acc = !mux_mode && !s_rs;
		reg_rd = rd_go && !idx_acc;
		reg_wr = wr_go && !idx_acc;
		ale_fall = mux_mode && (cfg_ff[B_LATCH_PIN_TWO] ? (p_latch_pin_two && !s_latch_pin_two)
			: (p_latch_pin_one && !s_latch_pin_one));
		pkt_pop = rd_of(IDX_PACKET_FIFO_PORT);
	end

	// ****************************************
	// Packet FIFO
	// ****************************************
	always_comb begin
		// Cap at the packet size although the store is deeper
		pkt_push = host_evt.wr_stb && hctl_ff[B_PKTSEL] && !full_ff
			&& pkt_in_rdy && (pkt_cnt < PKT_BYTES[$clog2(PKT_FIFO_DEPTH):0]);
	end

	byte_fifo #(.WIDTH(8), .DEPTH(PKT_FIFO_DEPTH)) u_pkt_fifo (
		.clock(clock),
		.rst_b(rst_b),
		.flush(sys_evt.fw_reset),
		.in_valid(pkt_push),
		.in_ready(pkt_in_rdy),
		.in_data(host_evt.wr_data),
		.out_valid(pkt_valid),
		.out_ready(pkt_pop),
		.out_data(pkt_data),
		.count(pkt_cnt)
	);

	// ****************************************
	// Read mux
	// ****************************************
	always_comb begin
		rd_val = 8'h0000;
		if (idx_acc) begin
			rd_val = index_ff;
		end else begin
			case (index_ff)
				IDX_PACKET_FIFO_PORT: rd_val = pkt_valid ? pkt_data : EMPTY_READ;
				IDX_IRQ: rd_val = ~{pne_ff, tend_ff, sri_ff,
					hci_ff | devrst_ff, busy_ff, api_ff,
					(dfc_ff == DF_BYTES), sci_ff};
				IDX_WCL: rd_val = wc_ff[7:0];
				IDX_WCH: rd_val = {4'h0, wc_ff[11:8]};
				IDX_APKT: rd_val = {apkt_ff, 7'h00};
				IDX_DFCTL: rd_val = {6'h00, diro_ff, 1'b0};
				IDX_HCTL: rd_val = hctl_ff;
				IDX_SUB: rd_val = {5'h00, subc_ff};
				IDX_DATA_FIFO_RESET: rd_val = {4'h0, data_fifo_reset_ff, 3'h0};
				IDX_SUBEN: rd_val = {3'h0, subcode_irq_en_ff, 4'h0};
				IDX_HIEN: rd_val = hien_ff;
				IDX_RSTEN: rd_val = rsten_ff;
				IDX_XSTAT: rd_val = {2'h0, dir_ff, 1'b0, devrst_ff, 1'b0,
					full_ff, 1'b0};
				IDX_BCL: rd_val = bcl_ff;
				IDX_CMD: rd_val = cmd_ff;
				IDX_MUX: rd_val = mux_ff;
				IDX_CFG: rd_val = cfg_ff;
				IDX_PLAY: rd_val = play_ff;
				default: rd_val = 8'h0000;
			endcase
		end
	end

	// ****************************************
	// Bus-facing next state
	// ****************************************
	always_comb begin
		nxt_pins_p = pins_s;
		nxt_index = index_ff;
		if (ale_fall) begin
			nxt_index = s_ud;
		end else if (wr_go && idx_acc) begin
			nxt_index = s_ud;
		end else if ((reg_rd && !pkt_pop) || reg_wr) begin
			nxt_index = {index_ff[7:4], index_ff[3:0] + 4'h1};
		end
		nxt_ud_out = rd_go ? rd_val : ud_out_ff;
		nxt_ud_oe = !s_cs_b && !s_rd_b;
		nxt_hwr_rdy = hctl_ff[B_PKTSEL] && !full_ff && pkt_in_rdy
			&& (pkt_cnt < PKT_BYTES[$clog2(PKT_FIFO_DEPTH):0]);
		// Open drain: enable pulls the pin low
		nxt_irq = (pne_ff && irq_enable_ctrl_ff[B_PNE_EN])
			|| (tend_ff && irq_enable_ctrl_ff[B_TEND_EN])
			|| (sri_ff && irq_enable_ctrl_ff[B_SRI_EN])
			|| hci_ff || devrst_ff || api_ff || sci_ff;
	end

	// ****************************************
	// Configuration next state
	// ****************************************
	logic a0_cmd;
	always_comb begin
		a0_cmd = host_evt.cmd_valid && host_evt.selected
			&& (host_evt.cmd_code == CMD_PACKET);
		nxt_irq_enable_ctrl = irq_enable_ctrl_ff;
		nxt_mux = wr_to(IDX_MUX) ? s_ud : mux_ff;
		nxt_cfg = wr_to(IDX_CFG) ? s_ud : cfg_ff;
		nxt_hctl = wr_to(IDX_HCTL) ? s_ud : hctl_ff;
		nxt_hctl[B_CLEAR_BUSY] = 1'b0;
		nxt_hien = wr_to(IDX_HIEN) ? s_ud : hien_ff;
		nxt_rsten = wr_to(IDX_RSTEN) ? s_ud : rsten_ff;
		nxt_bcl = wr_to(IDX_BCL) ? s_ud : bcl_ff;
		nxt_play = wr_to(IDX_PLAY) ? s_ud : play_ff;
		nxt_apkt = wr_to(IDX_APKT) ? s_ud[B_APKT] : apkt_ff;
		nxt_diro = wr_to(IDX_DFCTL) ? s_ud[B_DIRO] : diro_ff;
		nxt_data_fifo_reset = wr_to(IDX_DATA_FIFO_RESET) ? s_ud[B_DATA_FIFO_RESET] : data_fifo_reset_ff;
		nxt_subcode_irq_en = wr_to(IDX_SUBEN) ? s_ud[B_SUBCODE_IRQ_EN] : subcode_irq_en_ff;
		nxt_cmd = host_evt.cmd_valid ? host_evt.cmd_code : cmd_ff;
		if (wr_to(IDX_IRQ)) begin
			nxt_irq_enable_ctrl = {s_ud[7:5], 3'h0, s_ud[B_DT_EN], 1'b0};
		end
		if (hien_ff[B_HOST_IRQ_EN] && a0_cmd) begin
			nxt_irq_enable_ctrl[B_TEND_EN] = 1'b1;
		end
		if ((wr_to(IDX_AUTO) && s_ud[B_AUTO]) || (apkt_ff && a0_cmd)) begin
			nxt_irq_enable_ctrl[B_DT_EN] = 1'b1;
		end
		if (sys_evt.fw_reset) begin
			nxt_irq_enable_ctrl[B_PNE_EN] = 1'b0;
			nxt_irq_enable_ctrl[B_TEND_EN] = 1'b0;
		end
		if (sys_evt.fw_reset || sys_evt.host_reset || sys_evt.dec_reset) begin
			nxt_irq_enable_ctrl[B_SRI_EN] = 1'b0;
		end
	end

	// ****************************************
	// Event flags next state
	// ****************************************
	logic trig, word_end, thr_hit, tend_set, tend_clr, df_clr, hci_set;
	logic [2:0] sub_rise;
	always_comb begin
		// The automatic trigger raises its own enable, so it needs none
		trig = (irq_enable_ctrl_ff[B_DT_EN] && wr_to(IDX_TRIG))
			|| (wr_to(IDX_AUTO) && s_ud[B_AUTO]);
		word_end = busy_ff && host_evt.word_rd && (wc_ff == 12'h000);
		nxt_wc = wc_ff;
		if (wr_to(IDX_WCL)) begin
			nxt_wc[7:0] = s_ud;
		end else if (wr_to(IDX_WCH)) begin
			nxt_wc[11:8] = s_ud[3:0];
		end else if (busy_ff && host_evt.word_rd && !word_end) begin
			nxt_wc = wc_ff - 12'h001;
		end
		nxt_drqp = host_evt.drq;
		nxt_thr = (host_evt.drq && !drqp_ff) ? bcl_ff[3:0] : thr_ff;
		nxt_push = pkt_push;
		// Only a fresh arrival reaches the threshold; an ack must not re-fire
		thr_hit = !full_ff && push_ff && (thr_ff != 4'h0)
			&& (pkt_cnt == {{($clog2(PKT_FIFO_DEPTH)-3){1'b0}}, thr_ff});
		nxt_full = thr_hit || (full_ff && !wr_to(IDX_XACK));
		tend_set = thr_hit || word_end || host_evt.out_done;
		nxt_dir = thr_hit ? 1'b0 : ((word_end || host_evt.out_done)
			? 1'b1 : dir_ff);
		// Data-in end holds until both acks have been written
		nxt_dineed = word_end || (dineed_ff && !wr_to(IDX_DIACK));
		nxt_xgot = !tend_set && (xgot_ff || wr_to(IDX_XACK));
		tend_clr = nxt_xgot && !nxt_dineed;
		if (tend_clr) begin
			nxt_xgot = 1'b0;
		end
		nxt_tend = tend_set || (tend_ff && !tend_clr);
		nxt_pne = pkt_push || (pne_ff && !(pkt_pop
			&& (pkt_cnt == 1) && !sys_evt.fw_reset));
		if (sys_evt.fw_reset && !pkt_push) begin
			nxt_pne = 1'b0;
		end
		nxt_sri = (cfg_ff[B_REMAP] ? (|sys_evt.target_evt)
			: sys_evt.sector_ready)
			|| (sri_ff && !(rd_of(IDX_STATUS_THREE) || rd_of(IDX_LATCHED_STATUS_THREE)
			|| rd_of(IDX_TSTA)));
		hci_set = (hien_ff[B_HOST_IRQ_EN] && (host_evt.soft_reset
			|| (host_evt.cmd_valid && host_evt.cmd_code == CMD_DIAG)
			|| (host_evt.cmd_valid && host_evt.selected
			&& host_evt.cmd_code != CMD_PACKET
			&& host_evt.cmd_code != CMD_DEVRST)))
			|| (hien_ff[B_ABSENT_SLAVE_EN] && host_evt.absent_slave);
		nxt_hci = hci_set || (hci_ff && !(sys_evt.host_reset
			|| rd_of(IDX_CMD) || (wr_to(IDX_HCTL)
			&& s_ud[B_CLEAR_BUSY])));
		nxt_devrst = (rsten_ff[B_RSTIEN] && host_evt.cmd_valid
			&& host_evt.cmd_code == CMD_DEVRST)
			|| (devrst_ff && !wr_to(IDX_XSTAT));
		nxt_busy = trig || (busy_ff && !word_end
			&& irq_enable_ctrl_ff[B_DT_EN]);
		nxt_api = (play_ff[1:0] != 2'h0 && play_ff[B_PLAYBACK_IRQ_EN]
			&& sys_evt.play_done)
			|| (api_ff && !wr_to(IDX_PACK));
		nxt_subp = sys_evt.subcode;
		sub_rise = sys_evt.subcode & ~subp_ff;
		nxt_subc = (subcode_irq_en_ff ? sub_rise : 3'h0)
			| (wr_to(IDX_SUB) ? 3'h0 : subc_ff);
		nxt_sci = (subcode_irq_en_ff && (|sub_rise))
			|| (sci_ff && !wr_to(IDX_SUB));
		df_clr = sys_evt.host_reset || sys_evt.fw_reset
			|| !irq_enable_ctrl_ff[B_DT_EN] || diro_ff || data_fifo_reset_ff
			|| word_end;
		nxt_dfc = dfc_ff;
		if (df_clr) begin
			nxt_dfc = 6'h00;
		end else if (busy_ff && (dfc_ff != DF_BYTES)) begin
			nxt_dfc = dfc_ff + 6'h01;
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			pins_p_ff <= '1;
			index_ff <= 8'h0000;
			ud_out_ff <= 8'h0000;
			ud_oe_ff <= 1'b0;
			irq_ff <= 1'b0;
			hwr_rdy_ff <= 1'b0;
		end else begin
			pins_p_ff <= nxt_pins_p;
			index_ff <= nxt_index;
			ud_out_ff <= nxt_ud_out;
			ud_oe_ff <= nxt_ud_oe;
			irq_ff <= nxt_irq;
			hwr_rdy_ff <= nxt_hwr_rdy;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			irq_enable_ctrl_ff <= 8'h0000;
			mux_ff <= 8'h0000;
			cfg_ff <= 8'h0000;
			hctl_ff <= 8'h0000;
			hien_ff <= 8'h0000;
			rsten_ff <= 8'h0000;
			bcl_ff <= 8'h0000;
			play_ff <= 8'h0000;
			cmd_ff <= 8'h0000;
			apkt_ff <= 1'b0;
			diro_ff <= 1'b0;
			data_fifo_reset_ff <= 1'b0;
			subcode_irq_en_ff <= 1'b0;
		end else begin
			irq_enable_ctrl_ff <= nxt_irq_enable_ctrl;
			mux_ff <= nxt_mux;
			cfg_ff <= nxt_cfg;
			hctl_ff <= nxt_hctl;
			hien_ff <= nxt_hien;
			rsten_ff <= nxt_rsten;
			bcl_ff <= nxt_bcl;
			play_ff <= nxt_play;
			cmd_ff <= nxt_cmd;
			apkt_ff <= nxt_apkt;
			diro_ff <= nxt_diro;
			data_fifo_reset_ff <= nxt_data_fifo_reset;
			subcode_irq_en_ff <= nxt_subcode_irq_en;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			wc_ff <= 12'h000;
			thr_ff <= THRESH_RST;
			dfc_ff <= 6'h00;
			subc_ff <= 3'h0;
			subp_ff <= 3'h0;
			{pne_ff, tend_ff, full_ff, dir_ff, sri_ff, hci_ff} <= 6'h00;
			{devrst_ff, busy_ff, api_ff, sci_ff} <= 4'h0;
			{dineed_ff, xgot_ff, drqp_ff} <= 3'h0;
			push_ff <= 1'b0;
		end else begin
			wc_ff <= nxt_wc;
			thr_ff <= nxt_thr;
			dfc_ff <= nxt_dfc;
			subc_ff <= nxt_subc;
			subp_ff <= nxt_subp;
			{pne_ff, tend_ff, full_ff, dir_ff, sri_ff, hci_ff} <=
				{nxt_pne, nxt_tend, nxt_full, nxt_dir, nxt_sri, nxt_hci};
			{devrst_ff, busy_ff, api_ff, sci_ff} <=
				{nxt_devrst, nxt_busy, nxt_api, nxt_sci};
			{dineed_ff, xgot_ff, drqp_ff} <= {nxt_dineed, nxt_xgot, nxt_drqp};
			push_ff <= nxt_push;
		end
	end

	assign ud_out = ud_out_ff;
	assign ud_oe = ud_oe_ff;
	assign ctrl_irq_pin_oe = irq_ff;
	assign host_wr_ready = hwr_rdy_ff;
endmodule : upc_index_irq

/* tb/upc_index_irq_monitor.sv */
// Port-level checker for the indexed register block.
// Assumes the pin strobes are idle high whenever reset is held.
`timescale 1ns/1ps
module upc_index_irq_monitor import upc_pkg::*; #(
	parameter int PKT_FIFO_DEPTH = PKT_DEPTH
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic cs_b,
	input wire logic rd_b,
	input wire logic wr_b,
	input wire logic [7:0] ud_out,
	input wire logic ud_oe,
	input wire logic ctrl_irq_pin_oe,
	input wire host_evt_t host_evt,
	input wire logic host_wr_ready,
	input wire sys_evt_t sys_evt
);
	// ****************************************
	// Quiet-time counter
	// ****************************************
	logic [3:0] quiet_ff;
	logic [3:0] nxt_quiet;
	// Outputs may only move a few cycles after some bus access or event
	always_comb begin
		nxt_quiet = quiet_ff;
		if (!cs_b || host_evt != '0 || sys_evt != '0) nxt_quiet = 4'h0;
		else if (quiet_ff != 4'hF) nxt_quiet = quiet_ff + 4'h1;
	end
	always_ff @(posedge clock) begin
		if (!rst_b) quiet_ff <= 4'h0;
		else quiet_ff <= nxt_quiet;
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);
	property p_oe_track; ud_oe == $past(!cs_b && !rd_b, 3); endproperty
	a_oe_track: assert property (p_oe_track)
		else $error("data enable off the strobe timing");
	property p_out_hold; $changed(ud_out) |-> $rose(ud_oe); endproperty
	a_out_hold: assert property (p_out_hold)
		else $error("read data moved outside a read");
	property p_oe_min; $rose(ud_oe) |=> ud_oe [*2]; endproperty
	a_oe_min: assert property (p_oe_min)
		else $error("data enable too short");
	property p_reset_idle;
		$rose(rst_b) |-> (!ctrl_irq_pin_oe && !host_wr_ready && !ud_oe) [*2];
	endproperty
	a_reset_idle: assert property (p_reset_idle)
		else $error("outputs active after reset");
	property p_reset_out; $rose(rst_b) |-> ud_out == 8'h00; endproperty
	a_reset_out: assert property (p_reset_out)
		else $error("read data not cleared by reset");
	property p_irq_rise; $rose(ctrl_irq_pin_oe) |-> quiet_ff < 4'h9; endproperty
	a_irq_rise: assert property (p_irq_rise)
		else $error("interrupt raised without a cause");
	property p_irq_fall; $fell(ctrl_irq_pin_oe) |-> quiet_ff < 4'h9; endproperty
	a_irq_fall: assert property (p_irq_fall)
		else $error("interrupt released without a cause");
	property p_ready_cause;
		$changed(host_wr_ready) |-> quiet_ff < 4'h9;
	endproperty
	a_ready_cause: assert property (p_ready_cause)
		else $error("host ready moved without a cause");
endmodule : upc_index_irq_monitor
bind upc_index_irq upc_index_irq_monitor #(
	.PKT_FIFO_DEPTH(PKT_FIFO_DEPTH)
) upc_index_irq_monitor_inst (.clock(clock), .rst_b(rst_b), .cs_b(cs_b),
	.rd_b(rd_b), .wr_b(wr_b), .ud_out(ud_out), .ud_oe(ud_oe),
	.ctrl_irq_pin_oe(ctrl_irq_pin_oe), .host_evt(host_evt),
	.host_wr_ready(host_wr_ready), .sys_evt(sys_evt));

/* tb/uc_model.sv */
// Behavioural microcontroller on the register bus pins.
// Assumes pins move on the falling clock edge; data bus has pull-ups.
`timescale 1ns/1ps
module uc_model (
	input wire logic clock,
	input wire logic [7:0] ud_out,
	input wire logic ud_oe,
	output logic cs_b,
	output logic rd_b,
	output logic wr_b,
	output logic reg_select_pin,
	output logic latch_pin_one,
	output logic latch_pin_two,
	output logic [7:0] ud_in
);
	logic drv;
	logic [7:0] dq;
	// A released bus floats up to all ones
	assign ud_in = drv ? dq : (ud_oe ? ud_out : 8'hFF);
	initial begin
		{cs_b, rd_b, wr_b, reg_select_pin} = 4'hF;
		{latch_pin_one, latch_pin_two, drv} = 3'h0;
		dq = 8'h00;
	end
	task automatic access(input logic rd, input logic rs,
		input logic [7:0] d, output logic [7:0] q);
		@(negedge clock);
		cs_b = 1'b0;
		reg_select_pin = rs;
		dq = d;
		drv = !rd;
		@(negedge clock);
		if (rd) rd_b = 1'b0;
		else wr_b = 1'b0;
		// Four cycles low covers the two-flop pin synchroniser
		repeat (4) @(negedge clock);
		q = ud_out;
		rd_b = 1'b1;
		wr_b = 1'b1;
		repeat (4) @(negedge clock);
		cs_b = 1'b1;
		drv = 1'b0;
		repeat (3) @(negedge clock);
	endtask : access
	task automatic latch(input logic [7:0] idx, input logic two);
		@(negedge clock);
		drv = 1'b1;
		dq = idx;
		latch_pin_one = !two;
		latch_pin_two = two;
		repeat (3) @(negedge clock);
		{latch_pin_one, latch_pin_two} = 2'h0;
		repeat (4) @(negedge clock);
		drv = 1'b0;
	endtask : latch
endmodule : uc_model

/* tb/test_upc_index_irq.sv */
// Self-checking bench: controller model on the pins, host events by hand.
// Assumes one 100 MHz clock; all stimulus moves on the falling edge.
`timescale 1ns/1ps
module test_upc_index_irq import upc_pkg::*;;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	host_evt_t he = '0;
	sys_evt_t se = '0;
	logic cs_b, rd_b, wr_b, rs, l1, l2, ud_oe, irq_oe, wr_ready;
	logic [7:0] ud_in, ud_out, q;
	int fails = 0;
	int compares = 0;
	always #5 clock = ~clock;
	upc_index_irq upc_index_irq_inst (.clock(clock), .rst_b(rst_b),
		.cs_b(cs_b), .rd_b(rd_b), .wr_b(wr_b), .reg_select_pin(rs),
		.latch_pin_one(l1), .latch_pin_two(l2), .ud_in(ud_in),
		.ud_out(ud_out), .ud_oe(ud_oe), .ctrl_irq_pin_oe(irq_oe),
		.host_evt(he), .host_wr_ready(wr_ready), .sys_evt(se));
	uc_model uc_model_inst (.clock(clock), .ud_out(ud_out), .ud_oe(ud_oe),
		.cs_b(cs_b), .rd_b(rd_b), .wr_b(wr_b), .reg_select_pin(rs),
		.latch_pin_one(l1), .latch_pin_two(l2), .ud_in(ud_in));
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		uc_model_inst.access(1'b0, 1'b0, idx, q);
		uc_model_inst.access(1'b0, 1'b1, d, q);
	endtask : wr
	task automatic rd(input logic [7:0] idx, input logic [7:0] m,
		input logic [7:0] exp);
		uc_model_inst.access(1'b0, 1'b0, idx, q);
		uc_model_inst.access(1'b1, 1'b1, 8'h00, q);
		check(q & m, exp);
	endtask : rd
	task automatic hwrite(input logic [7:0] d);
		@(negedge clock);
		he.wr_stb = 1'b1;
		he.wr_data = d;
		@(negedge clock);
		he.wr_stb = 1'b0;
		repeat (3) @(negedge clock);
	endtask : hwrite
	task automatic wait_irq(input logic exp);
		int n;
		n = 0;
		// The pin lags its flag by a cycle, so allow a short settle
		while (irq_oe !== exp && n < 20) begin
			@(negedge clock);
			n++;
		end
		check({7'h00, irq_oe}, {7'h00, exp});
	endtask : wait_irq
	// Drain the packet port from index 00h; it must not advance
	task automatic drain(input logic [7:0] base);
		uc_model_inst.access(1'b0, 1'b0, IDX_PACKET_FIFO_PORT, q);
		for (int i = 0; i < 4; i++) begin
			uc_model_inst.access(1'b1, 1'b1, 8'h00, q);
			check(q, (i < 3) ? base + 8'(i) : EMPTY_READ);
		end
	endtask : drain
	task automatic t_index();
		wr(IDX_WCL, 8'h5A);
		uc_model_inst.access(1'b1, 1'b0, 8'h00, q);
		check(q, 8'h03);
		rd(IDX_WCL, 8'hFF, 8'h5A);
		rd(8'hF0, 8'hFF, 8'h00);
		uc_model_inst.access(1'b0, 1'b0, IDX_STATUS_THREE, q);
		uc_model_inst.access(1'b1, 1'b1, 8'h00, q);
		uc_model_inst.access(1'b1, 1'b0, 8'h00, q);
		check(q, 8'h00);
	endtask : t_index
	task automatic t_packet();
		wr(IDX_IRQ, 8'h80);
		wr(IDX_HCTL, 8'h04);
		check({7'h00, wr_ready}, 8'h01);
		for (int i = 0; i < 3; i++) hwrite(8'hA0 + 8'(i));
		wait_irq(1'b1);
		rd(IDX_IRQ, 8'hFF, 8'h7F);
		drain(8'hA0);
		wait_irq(1'b0);
	endtask : t_packet
	task automatic t_full();
		wr(IDX_BCL, 8'hF3);
		@(negedge clock);
		he.drq = 1'b1;
		for (int i = 0; i < 5; i++) hwrite(8'hB0 + 8'(i));
		check({7'h00, wr_ready}, 8'h00);
		rd(IDX_IRQ, 8'h40, 8'h00);
		rd(IDX_XSTAT, 8'h22, 8'h02);
		wr(IDX_XACK, 8'h00);
		rd(IDX_IRQ, 8'h40, 8'h40);
		drain(8'hB0);
		he.drq = 1'b0;
	endtask : t_full
	task automatic t_cmd();
		wr(IDX_HIEN, 8'h80);
		@(negedge clock);
		he.selected = 1'b1;
		he.cmd_valid = 1'b1;
		he.cmd_code = CMD_PACKET;
		@(negedge clock);
		he.cmd_valid = 1'b0;
		he.out_done = 1'b1;
		@(negedge clock);
		he.out_done = 1'b0;
		wait_irq(1'b1);
		rd(IDX_XSTAT, 8'h20, 8'h20);
		se.fw_reset = 1'b1;
		@(negedge clock);
		se.fw_reset = 1'b0;
		wait_irq(1'b0);
		wr(IDX_XACK, 8'h00);
		rd(IDX_IRQ, 8'h40, 8'h40);
		he.selected = 1'b0;
	endtask : t_cmd
	task automatic t_xfer();
		wr(IDX_WCL, 8'h01);
		wr(IDX_WCH, 8'h00);
		wr(IDX_IRQ, 8'h02);
		wr(IDX_TRIG, 8'h00);
		rd(IDX_IRQ, 8'h08, 8'h00);
		repeat (2) begin
			@(negedge clock);
			he.word_rd = 1'b1;
			@(negedge clock);
			he.word_rd = 1'b0;
		end
		rd(IDX_IRQ, 8'h48, 8'h08);
		wr(IDX_XACK, 8'h00);
		rd(IDX_IRQ, 8'h40, 8'h00);
		wr(IDX_DIACK, 8'h00);
		rd(IDX_IRQ, 8'h40, 8'h40);
		wr(IDX_TRIG, 8'h00);
		wr(IDX_IRQ, 8'h00);
		rd(IDX_IRQ, 8'h08, 8'h08);
		wr(IDX_AUTO, 8'h04);
		rd(IDX_IRQ, 8'h08, 8'h00);
		rd(IDX_IRQ, 8'h02, 8'h00);
	endtask : t_xfer
	task automatic t_sector();
		wr(IDX_IRQ, 8'h20);
		@(negedge clock);
		se.sector_ready = 1'b1;
		@(negedge clock);
		se.sector_ready = 1'b0;
		wait_irq(1'b1);
		uc_model_inst.access(1'b0, 1'b0, IDX_LATCHED_STATUS_THREE, q);
		uc_model_inst.access(1'b1, 1'b1, 8'h00, q);
		wait_irq(1'b0);
	endtask : t_sector
	task automatic t_host();
		wr(IDX_RSTEN, 8'h02);
		@(negedge clock);
		he.cmd_valid = 1'b1;
		he.cmd_code = CMD_DEVRST;
		@(negedge clock);
		he.cmd_valid = 1'b0;
		wait_irq(1'b1);
		rd(IDX_CMD, 8'hFF, CMD_DEVRST);
		rd(IDX_IRQ, 8'h10, 8'h00);
		wr(IDX_XSTAT, 8'h00);
		rd(IDX_IRQ, 8'h10, 8'h10);
		wait_irq(1'b0);
	endtask : t_host
	task automatic t_mux();
		wr(IDX_WCL, 8'h3C);
		wr(IDX_MUX, 8'h02);
		uc_model_inst.latch(IDX_WCL, 1'b0);
		uc_model_inst.access(1'b1, 1'b0, 8'h00, q);
		check(q, 8'h3C);
		uc_model_inst.latch(IDX_CFG, 1'b0);
		uc_model_inst.access(1'b0, 1'b0, 8'h08, q);
		uc_model_inst.latch(IDX_WCL, 1'b1);
		uc_model_inst.access(1'b1, 1'b1, 8'h00, q);
		check(q, 8'h3C);
	endtask : t_mux
	task automatic summarize();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : summarize
	initial begin
		repeat (20) @(negedge clock);
		rst_b = 1'b1;
		t_index();
		t_packet();
		t_full();
		t_cmd();
		t_xfer();
		t_sector();
		t_host();
		t_mux();
		summarize();
	end
endmodule : test_upc_index_irq
